// *** shared/usc_regs.vh ***
/*
 * Constants of the configuration loader: register offsets, store word
 * layout, factory values and timing counts.
 * Assumes a 200 MHz aclk and 32-bit AXI4-Lite byte addressing.
 */
// Overview of operation
// - After power-on or USB reset, scan the store before presenting to the host.
// - Serial-number enable defaults set; a unique serial number is reported.
// - With suspend pull-down set, pull serial lines low throughout USB suspend.
// - Ring-indicate low with remote wake enabled wakes the host in about 20 ms.
// - Report the stored USB version, default 0200, yet run only at full speed.
// - Report 90 mA maximum bus current and bus-powered source by default.
// - Default pin 0 transmit lamp, pin 1 receive lamp, pin 2 line-driver enable.
// - Default pin 3 power enable: low after enumeration, high in suspend.
// - Default pin 4 sleep indicator: low in suspend, high otherwise.
// - Each of the eight serial and modem lines has its own inversion option.
// - Internal oscillator by default; external only when selected; fault otherwise.
// - The store is writable by the host so descriptors and options change.
// - Line-driver enable rises one bit before start, falls with the stop bit.
`ifndef USC_REGS_VH
`define USC_REGS_VH

// Register byte offsets
`define USC_REG_STATUS     8'h00
`define USC_REG_BIT_PERIOD 8'h04
`define USC_REG_APPLIED0   8'h08
`define USC_REG_STORE0     8'h40
`define USC_STORE_WORDS    4

// Status bit positions
`define USC_ST_LOADED   0
`define USC_ST_SCANNING 1
`define USC_ST_CLKFAULT 2
`define USC_ST_WAKE     3
`define USC_ST_SUSPEND  4
`define USC_ST_DRVEN    5

// Store word 1 fields
`define USC_W1_PWR_LSB   16
`define USC_W1_SELF_PWR  24
`define USC_W1_WAKE_EN   25
`define USC_W1_SERIAL_EN 26
`define USC_W1_PULLDOWN  27
`define USC_W1_EXT_OSC   28
`define USC_W1_HI_DRIVE  29
`define USC_W1_VSD_EN    30
// Store word 2 fields: pin functions 4 bits each, inversion at bit 20
`define USC_W2_INV_LSB   20

// Pin function codes
`define USC_FN_TX_LAMP  4'h0
`define USC_FN_RX_LAMP  4'h1
`define USC_FN_DRV_EN   4'h2
`define USC_FN_PWR_EN   4'h3
`define USC_FN_SLEEP    4'h4

// Factory values
`define USC_ID_DEFAULT      32'h1234_abcd
`define USC_W1_DEFAULT      32'h465a_0200
`define USC_USB_VER_DEFAULT 16'h0200
`define USC_W2_DEFAULT      32'h0004_3210
`define USC_SERIAL_DEFAULT  32'h0000_0001
`define USC_BIT_PERIOD_RST  16'h06c8

// Timing
`define USC_CLK_KHZ      200000
`define USC_WAKE_MS      20
`define USC_WAKE_CYCLES  (`USC_WAKE_MS * `USC_CLK_KHZ)
`define USC_LAMP_CYCLES  1000000

// AXI responses
`define USC_RESP_OKAY   2'b00
`define USC_RESP_SLVERR 2'b10

`endif

// *** logic/usc_line_driver.v ***
/*
 * RS485 line-driver enable timing for the serial transmitter.
 * Assumes the transmitter asks with frame_req and reports stop_bit pulses.
 */
`timescale 1ns/100ps
`default_nettype none
`include "usc_regs.vh"

module usc_line_driver (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // Timing
    input  wire [15:0] bit_cycles,
    // Transmitter handshake
    input  wire        frame_req,
    input  wire        stop_bit,
    output reg         start_go,
    output reg         drv_en
);

    reg  [15:0] lead_cnt;
    reg         leading;

    always @(posedge aclk) begin
        if (!aresetn) begin
            drv_en   <= 1'b0;
            leading  <= 1'b0;
            lead_cnt <= 16'h0000;
            start_go <= 1'b0;
        end else begin
            start_go <= 1'b0;
            if (frame_req && !drv_en) begin
                drv_en   <= 1'b1;
                leading  <= 1'b1;
                lead_cnt <= 16'h0001;
            end else if (leading) begin
                // One full bit period of lead before the start bit
                if (lead_cnt >= bit_cycles) begin
                    leading  <= 1'b0;
                    start_go <= 1'b1;
                end else begin
                    lead_cnt <= lead_cnt + 16'h0001;
                end
            end else if (stop_bit) begin
                drv_en <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// *** logic/usc_config_loader.v ***
/*
 * Configuration loader: store, scan after reset, applied settings,
 * configurable pins, line inversion, suspend and wake, AXI4-Lite slave.
 * Assumes the USB core reports reset, enumeration and suspend as levels.
 */
`timescale 1ns/100ps
`default_nettype none
`include "usc_regs.vh"

module usc_config_loader #(
    parameter [31:0] WAKE_CYCLES = `USC_WAKE_CYCLES,
    parameter [31:0] LAMP_CYCLES = `USC_LAMP_CYCLES,
    parameter [31:0] VENDOR_PRODUCT = `USC_ID_DEFAULT,   // Arbitrary value
    parameter [31:0] SERIAL_NUMBER  = `USC_SERIAL_DEFAULT
) (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite slave
    input  wire [7:0]  awaddr,
    input  wire        awvalid,
    output reg         awready,
    input  wire [31:0] wdata,
    input  wire [3:0]  wstrb,
    input  wire        wvalid,
    output reg         wready,
    output reg  [1:0]  bresp,
    output reg         bvalid,
    input  wire        bready,
    input  wire [7:0]  araddr,
    input  wire        arvalid,
    output reg         arready,
    output reg  [31:0] rdata,
    output reg  [1:0]  rresp,
    output reg         rvalid,
    input  wire        rready,
    // USB core status
    input  wire        usb_reset,
    input  wire        usb_enumerated,
    input  wire        usb_suspend,
    input  wire        ext_clk_present,
    output reg         config_ready,
    output reg         host_wake,
    // Applied descriptor fields
    output wire [31:0] vendor_product,
    output wire [15:0] usb_version,
    output wire [7:0]  max_power_ma,
    output wire        self_powered,
    output wire        serial_number_en,
    output wire [31:0] serial_number,
    output wire        virtual_serial_driver_en,
    output wire        high_drive,
    output wire        ext_osc_select,
    output reg         full_speed_only,
    output reg         clock_fault,
    // Transmitter handshake and activity
    input  wire        tx_frame_req,
    input  wire        tx_stop_bit,
    input  wire        tx_activity,
    input  wire        rx_activity,
    output wire        tx_start_go,
    // Serial lines, core side: txd, rts, dtr out; rxd, cts, dsr, dcd, ri in
    input  wire [2:0]  core_out,
    output reg  [4:0]  core_in,
    // Serial lines, pin side
    output reg  [2:0]  serial_pin_out,
    input  wire [3:0]  serial_pin_in,
    input  wire        ring_indicate_n,
    output reg         serial_pull_down,
    // Configurable pins
    output reg  [4:0]  config_pin,
    output reg  [4:0]  config_pin_oe
);

    localparam ST_HOLD = 3'b001;
    localparam ST_SCAN = 3'b010;
    localparam ST_DONE = 3'b100;
    localparam DEPTH   = `USC_STORE_WORDS;
    // Word 0 ids, word 1 power and options, word 2 pins, word 3 serial
    reg  [31:0] store   [0:DEPTH-1];
    reg  [31:0] applied [0:DEPTH-1];
    reg  [2:0]  state;
    reg  [1:0]  scan_idx;
    reg  [15:0] bit_period;
    reg  [31:0] wake_cnt, tx_lamp_cnt, rx_lamp_cnt;
    reg  [7:0]  aw_addr;
    reg         aw_got;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg         w_got;
    wire        drv_en, suspended;
    wire [7:0]  inv;
    wire        ri_line;
    reg  [4:0]  next_pin, next_oe;
    integer     i, b, k, n;

    function [31:0] factory_word;
        input [1:0] idx;
        begin
            case (idx)
                2'd0:    factory_word = VENDOR_PRODUCT;
                2'd1:    factory_word = `USC_W1_DEFAULT;
                2'd2:    factory_word = `USC_W2_DEFAULT;
                default: factory_word = SERIAL_NUMBER;
            endcase
        end
    endfunction

    function in_block;
        input [7:0] addr;
        input [7:0] base;
        begin
            in_block = (addr >= base) && (addr < base + 8'd4 * DEPTH);
        end
    endfunction

    // Nonvolatile contents survive every reset; factory values load them and AXI4-Lite writes change them
    initial begin
        for (k = 0; k < DEPTH; k = k + 1) begin
            store[k] = factory_word(k[1:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Applied fields
    assign vendor_product           = applied[0];
    assign usb_version              = applied[1][15:0];
    assign max_power_ma             = applied[1][`USC_W1_PWR_LSB +: 8];
    assign self_powered             = applied[1][`USC_W1_SELF_PWR];
    assign serial_number_en         = applied[1][`USC_W1_SERIAL_EN];
    assign serial_number            = applied[3];
    assign virtual_serial_driver_en = applied[1][`USC_W1_VSD_EN];
    assign high_drive               = applied[1][`USC_W1_HI_DRIVE];
    assign ext_osc_select           = applied[1][`USC_W1_EXT_OSC];
    assign inv                      = applied[2][`USC_W2_INV_LSB +: 8];
    assign suspended                = usb_suspend;
    assign ri_line                  = ring_indicate_n ^ inv[7];

    ////////////////////////////////////////////////////////////////////////////
    // Loader
    always @(posedge aclk) begin
        if (!aresetn) begin
            state        <= ST_HOLD;
            scan_idx     <= 2'd0;
            config_ready <= 1'b0;
            for (i = 0; i < DEPTH; i = i + 1) begin
                applied[i] <= 32'h0000_0000;
            end
        end else begin
            case (state)
                ST_HOLD: begin
                    config_ready <= 1'b0;
                    scan_idx     <= 2'd0;
                    if (!usb_reset) begin
                        state <= ST_SCAN;
                    end
                end
                ST_SCAN: begin
                    applied[scan_idx] <= store[scan_idx];
                    scan_idx          <= scan_idx + 2'd1;
                    if (usb_reset) begin
                        state <= ST_HOLD;
                    end else if (scan_idx == DEPTH - 1) begin
                        state        <= ST_DONE;
                        config_ready <= 1'b1;
                    end
                end
                ST_DONE: begin
                    // Store rewrites take effect only at the next reload
                    if (usb_reset) begin
                        state        <= ST_HOLD;
                        config_ready <= 1'b0;
                    end
                end
                default: begin
                    state <= ST_HOLD;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Line driver, lamps, wake
    usc_line_driver u_line_driver (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .bit_cycles (bit_period),
        .frame_req  (tx_frame_req),
        .stop_bit   (tx_stop_bit),
        .start_go   (tx_start_go),
        .drv_en     (drv_en)
    );

    always @(posedge aclk) begin
        if (!aresetn) begin
            tx_lamp_cnt <= 32'h0000_0000;
            rx_lamp_cnt <= 32'h0000_0000;
            wake_cnt    <= 32'h0000_0000;
            host_wake   <= 1'b0;
        end else begin
            // One-shot stretches short bursts so the lamp is visible
            tx_lamp_cnt <= tx_activity ? LAMP_CYCLES : tx_lamp_cnt - (tx_lamp_cnt != 32'h0000_0000);
            rx_lamp_cnt <= rx_activity ? LAMP_CYCLES : rx_lamp_cnt - (rx_lamp_cnt != 32'h0000_0000);
            if (!suspended || !config_ready || !applied[1][`USC_W1_WAKE_EN] || ri_line) begin
                wake_cnt  <= 32'h0000_0000;
                host_wake <= host_wake && suspended;
            end else if (wake_cnt >= WAKE_CYCLES - 32'd1) begin
                host_wake <= 1'b1;
            end else begin
                wake_cnt <= wake_cnt + 32'd1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pins
    always @* begin
        for (b = 0; b < 5; b = b + 1) begin
            next_pin[b] = 1'b0;
            next_oe[b]  = 1'b1;
            case (applied[2][4*b +: 4])
                `USC_FN_TX_LAMP: next_oe[b]  = tx_lamp_cnt != 32'h0000_0000;
                `USC_FN_RX_LAMP: next_oe[b]  = rx_lamp_cnt != 32'h0000_0000;
                `USC_FN_DRV_EN:  next_pin[b] = drv_en;
                `USC_FN_PWR_EN:  next_pin[b] = suspended || !usb_enumerated;
                `USC_FN_SLEEP:   next_pin[b] = !suspended;
                default: begin
                    next_pin[b] = 1'b1;
                    next_oe[b]  = 1'b0;
                end
            endcase
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            config_pin       <= 5'h1f;
            config_pin_oe    <= 5'h00;
            serial_pin_out   <= 3'h0;
            core_in          <= 5'h00;
            serial_pull_down <= 1'b0;
            full_speed_only  <= 1'b1;
            clock_fault      <= 1'b0;
        end else begin
            config_pin      <= next_pin;
            config_pin_oe   <= next_oe;
            full_speed_only <= 1'b1;
            // Selecting the external source without a clock leaves no way to run
            clock_fault     <= ext_osc_select && !ext_clk_present;
            serial_pull_down <= suspended && applied[1][`USC_W1_PULLDOWN];
            serial_pin_out   <= (suspended && applied[1][`USC_W1_PULLDOWN]) ? 3'h0 :
                                core_out ^ {inv[4], inv[2], inv[0]};
            core_in <= {ri_line, serial_pin_in ^ {inv[6], inv[5], inv[3], inv[1]}};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready    <= 1'b1;
            wready     <= 1'b1;
            bvalid     <= 1'b0;
            bresp      <= `USC_RESP_OKAY;
            aw_got     <= 1'b0;
            w_got      <= 1'b0;
            bit_period <= `USC_BIT_PERIOD_RST;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_got  <= 1'b1;
                aw_addr <= awaddr;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_got  <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (aw_got && w_got && !bvalid) begin
                aw_got <= 1'b0;
                w_got  <= 1'b0;
                bvalid <= 1'b1;
                bresp  <= `USC_RESP_OKAY;
                if (in_block(aw_addr, `USC_REG_STORE0)) begin
                    for (n = 0; n < 4; n = n + 1) begin
                        if (w_strb[n]) begin
                            store[aw_addr[3:2]][8*n +: 8] <= w_data[8*n +: 8];
                        end
                    end
                end else if (aw_addr == `USC_REG_BIT_PERIOD) begin
                    if (w_strb[0]) bit_period[7:0]  <= w_data[7:0];
                    if (w_strb[1]) bit_period[15:8] <= w_data[15:8];
                end else if (aw_addr != `USC_REG_STATUS && !in_block(aw_addr, `USC_REG_APPLIED0)) begin
                    bresp <= `USC_RESP_SLVERR;
                end
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `USC_RESP_OKAY;
        end else begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rresp   <= `USC_RESP_OKAY;
                rdata   <= 32'h0000_0000;
                if (araddr == `USC_REG_STATUS) begin
                    rdata <= {26'h000_0000, drv_en, suspended, host_wake, clock_fault,
                              state == ST_SCAN, config_ready};
                end else if (araddr == `USC_REG_BIT_PERIOD) begin
                    rdata <= {16'h0000, bit_period};
                end else if (in_block(araddr, `USC_REG_APPLIED0)) begin
                    rdata <= applied[araddr[3:2] - 2'd2];
                end else if (in_block(araddr, `USC_REG_STORE0)) begin
                    rdata <= store[araddr[3:2]];
                end else begin
                    rresp <= `USC_RESP_SLVERR;
                end
            end
            if (rvalid && rready) begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// *** bench/usc_chk.sv ***
/*
 * Port assertions for the configuration loader.
 * Assumes the factory pin functions and a bench that holds usb_reset several cycles.
 */
`timescale 1ns/100ps
`default_nettype none

module usc_chk (
    // Clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // Write channels
    input wire logic       awvalid,
    input wire logic       awready,
    input wire logic       wvalid,
    input wire logic       wready,
    input wire logic       bvalid,
    // USB status
    input wire logic       usb_reset,
    input wire logic       usb_suspend,
    input wire logic       config_ready,
    input wire logic       host_wake,
    input wire logic       ring_indicate_n,
    input wire logic       full_speed_only,
    // Oscillator
    input wire logic       ext_osc_select,
    input wire logic       ext_clk_present,
    input wire logic       clock_fault,
    // Transmitter and pins
    input wire logic       tx_start_go,
    input wire logic       tx_stop_bit,
    input wire logic [4:0] config_pin,
    input wire logic [4:0] config_pin_oe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////
    property p_rescan;
        usb_reset [*3] |-> !config_ready;
    endproperty
    a_rescan: assert property (p_rescan) else $error("ready during usb reset");
    property p_fs;
        full_speed_only;
    endproperty
    a_fs: assert property (p_fs) else $error("not full speed");
    property p_bresp;
        awvalid && awready && wvalid && wready |-> ##2 bvalid;
    endproperty
    a_bresp: assert property (p_bresp) else $error("no write response");
    property p_fault;
        clock_fault == $past(ext_osc_select && !ext_clk_present);
    endproperty
    a_fault: assert property (p_fault) else $error("clock fault wrong");
    // A wake needs ring held low well before it, not a single glitch
    property p_wake;
        $rose(host_wake) |-> usb_suspend && $past(ring_indicate_n, 8) == 1'b0;
    endproperty
    a_wake: assert property (p_wake) else $error("wake without cause");
    property p_unwake;
        !usb_suspend [*2] |-> !host_wake;
    endproperty
    a_unwake: assert property (p_unwake) else $error("wake outside suspend");
    property p_lead;
        $rose(tx_start_go) |-> config_pin[2] && config_pin_oe[2];
    endproperty
    a_lead: assert property (p_lead) else $error("driver not on at start");
    property p_stop;
        tx_stop_bit && config_pin[2] |-> ##2 !config_pin[2];
    endproperty
    a_stop: assert property (p_stop) else $error("driver on after stop");
    property p_susp;
        usb_suspend [*4] |-> config_pin[3] && !config_pin[4];
    endproperty
    a_susp: assert property (p_susp) else $error("suspend pins wrong");
endmodule

bind usc_config_loader usc_chk u_chk (
    .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
    .usb_reset, .usb_suspend, .config_ready, .host_wake, .ring_indicate_n,
    .full_speed_only, .ext_osc_select, .ext_clk_present, .clock_fault,
    .tx_start_go, .tx_stop_bit, .config_pin, .config_pin_oe
);
`default_nettype wire

// *** bench/usc_usb_host.sv ***
/*
 * Model of the USB host and core status around the loader.
 * Assumes the bench asks for bus resets and suspends by level.
 */
`timescale 1ns/100ps
`default_nettype none

module usc_usb_host (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Bench requests
    input  wire logic want_reset,
    input  wire logic want_suspend,
    // Loader status
    input  wire logic config_ready,
    input  wire logic host_wake,
    // Core levels
    output var  logic usb_reset,
    output var  logic usb_enumerated,
    output var  logic usb_suspend
);
    logic [1:0] wait_cnt;
    ////////////////////////////////////////////////////////////////
    always @(posedge aclk) begin
        usb_reset <= want_reset;
        if (!aresetn || usb_reset) begin
            usb_enumerated <= 1'b0;
            usb_suspend    <= 1'b0;
            wait_cnt       <= 2'h0;
        end else begin
            // Descriptors are fetched only once the store is scanned
            if (config_ready && !usb_enumerated) wait_cnt <= wait_cnt + 2'h1;
            if (wait_cnt == 2'h3) usb_enumerated <= 1'b1;
            // A wake request resumes the bus
            if (host_wake) usb_suspend <= 1'b0;
            else if (want_suspend && usb_enumerated) usb_suspend <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// *** bench/usc_tb.sv ***
/*
 * Self-checking bench for the configuration loader over AXI4-Lite.
 * Assumes short wake and lamp counts set through parameters.
 */
`timescale 1ns/100ps
`default_nettype none

module tb;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire         awready, wready, bvalid, arready, rvalid;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata, serial_number;
    logic        want_reset = 1'b0, want_suspend = 1'b0, ext_clk_present = 1'b0;
    wire         usb_reset, usb_enumerated, usb_suspend, config_ready, host_wake;
    wire  [15:0] usb_version;
    wire  [7:0]  max_power_ma;
    wire         self_powered, serial_number_en, ext_osc_select, full_speed_only, clock_fault;
    logic        tx_frame_req = 1'b0, tx_stop_bit = 1'b0, tx_activity = 1'b0, rx_activity = 1'b0;
    logic        ring_indicate_n = 1'b1;
    logic [2:0]  core_out = 3'h5;
    logic [3:0]  serial_pin_in = 4'ha;
    wire         tx_start_go, serial_pull_down;
    wire  [4:0]  core_in, config_pin, config_pin_oe;
    wire  [2:0]  serial_pin_out;
    int          n_mismatch = 0, n_compared = 0, i, k;

    usc_config_loader #(.WAKE_CYCLES(32'h0000_0010), .LAMP_CYCLES(32'h0000_0008),
        .SERIAL_NUMBER(32'h0000_5a3c)) uut (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .usb_reset, .usb_enumerated, .usb_suspend, .ext_clk_present, .config_ready, .host_wake,
        .vendor_product(), .usb_version, .max_power_ma, .self_powered, .serial_number_en,
        .serial_number, .virtual_serial_driver_en(), .high_drive(), .ext_osc_select,
        .full_speed_only, .clock_fault, .tx_frame_req, .tx_stop_bit, .tx_activity, .rx_activity,
        .tx_start_go, .core_out, .core_in, .serial_pin_out, .serial_pin_in, .ring_indicate_n,
        .serial_pull_down, .config_pin, .config_pin_oe);
    usc_usb_host host (.aclk, .aresetn, .want_reset, .want_suspend, .config_ready, .host_wake,
        .usb_reset, .usb_enumerated, .usb_suspend);

    always #2.5 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////
    task conclude;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask
    // Address and data are offered together; each is dropped once taken
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk("bresp", er, bresp);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk("rresp", er, rresp);
        chk("rdata", ed, rdata);
    endtask
    task wait_ready;
        k = 0;
        while (config_ready !== 1'b1 && k < 50) begin
            @(posedge aclk);
            k++;
        end
        repeat (10) @(posedge aclk);
        chk("config_ready", 1, config_ready);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        wait_ready();
        chk("usb_version", 32'h0000_0200, usb_version);
        chk("max_power", 32'h0000_005a, max_power_ma);
        chk("self_powered", 0, self_powered);
        chk("serial_en", 1, serial_number_en);
        chk("serial", 32'h0000_5a3c, serial_number);
        chk("ext_osc", 0, ext_osc_select);
        rd(8'h0c, 32'h465a_0200, 2'b00);
        rd(8'h30, 32'h0000_0000, 2'b10);
        wr(8'h30, 32'hffff_ffff, 2'b10);
        chk("pwr_en_n", 0, config_pin[3]);
        chk("sleep_n", 1, config_pin[4]);
        chk("pin_out", core_out, serial_pin_out);
        chk("core_in", {ring_indicate_n, serial_pin_in}, core_in);
        for (i = 0; i < 2; i++) begin
            tx_activity <= (i == 0);
            rx_activity <= (i == 1);
            @(posedge aclk);
            tx_activity <= 1'b0;
            rx_activity <= 1'b0;
            repeat (3) @(posedge aclk);
            chk("lamp_on", 1, config_pin_oe[i] & ~config_pin[i]);
            repeat (12) @(posedge aclk);
            chk("lamp_off", 0, config_pin_oe[i]);
        end
        wr(8'h04, 32'h0000_000a, 2'b00);
        tx_frame_req <= 1'b1;
        @(posedge aclk);
        tx_frame_req <= 1'b0;
        k = 0;
        while (!tx_start_go && k < 40) begin
            @(posedge aclk);
            k++;
        end
        chk("lead", 1, k == 10 || k == 11);
        repeat (3) @(posedge aclk);
        tx_stop_bit <= 1'b1;
        @(posedge aclk);
        tx_stop_bit <= 1'b0;
        repeat (3) @(posedge aclk);
        chk("drv_off", 0, config_pin[2]);
        want_suspend <= 1'b1;
        repeat (6) @(posedge aclk);
        chk("pwr_en_n", 1, config_pin[3]);
        chk("sleep_n", 0, config_pin[4]);
        chk("pull_down", 0, serial_pull_down);
        ring_indicate_n <= 1'b0;
        k = 0;
        while (!host_wake && k < 60) begin
            @(posedge aclk);
            k++;
        end
        chk("wake_time", 1, k >= 16 && k <= 20);
        want_suspend <= 1'b0;
        repeat (4) @(posedge aclk);
        chk("wake_clear", 0, host_wake);
        wr(8'h44, 32'h5e5a_0200, 2'b00);
        wr(8'h48, 32'h0ff4_3210, 2'b00);
        rd(8'h44, 32'h5e5a_0200, 2'b00);
        wr(8'h0c, 32'h0000_0000, 2'b00);
        rd(8'h0c, 32'h465a_0200, 2'b00);
        chk("osc_held", 0, ext_osc_select);
        want_reset <= 1'b1;
        repeat (5) @(posedge aclk);
        want_reset <= 1'b0;
        wait_ready();
        chk("osc_sel", 1, ext_osc_select);
        chk("clk_fault", 1, clock_fault);
        ext_clk_present <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("clk_ok", 0, clock_fault);
        chk("pin_inv", {29'h0, ~core_out}, serial_pin_out);
        chk("core_inv", {27'h0, ~ring_indicate_n, ~serial_pin_in}, core_in);
        want_suspend <= 1'b1;
        repeat (6) @(posedge aclk);
        chk("pull_down", 1, serial_pull_down);
        chk("pin_low", 0, serial_pin_out);
        conclude();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        #50000;
        n_mismatch++;
        $display("watchdog expired");
        conclude();
    end
endmodule
`default_nettype wire
